// ### src/dca_cfg.svh
`ifndef DCA_CFG_SVH
`define DCA_CFG_SVH

// Pin, column and extended mode register widths
`define DCA_ADDR_W      12
`define DCA_COL_W       8
`define DCA_DQ_W        16
`define DCA_EMR_W       13

// Address and mode register field positions
`define DCA_AP_BIT      10
`define DCA_BL_LSB      0
`define DCA_BL_MSB      2
`define DCA_CL_LSB      4
`define DCA_CL_MSB      6
`define DCA_DLL_BIT     0

// Mode field codes
`define DCA_BL2         3'h1
`define DCA_BL4         3'h2
`define DCA_BL8         3'h3
`define DCA_CL2         3'h2
`define DCA_CL3         3'h3

// Reset values
`define DCA_MR_RST      12'h000
`define DCA_EMR_RST     13'h0000

// Storage and buffering
`define DCA_MEM_WORDS   64
`define DCA_MEM_IDX_W   6
`define DCA_FIFO_DEPTH  16
`define DCA_FIFO_W      44

`endif

// ### src/dca_pkg.sv
`default_nettype none

package dca_pkg;

   // Command code is {ras_b, cas_b, we_b}
   typedef enum logic [2:0] {
      DCA_CMD_MRS = 3'h0,
      DCA_CMD_REF = 3'h1,
      DCA_CMD_PRE = 3'h2,
      DCA_CMD_ACT = 3'h3,
      DCA_CMD_WR  = 3'h4,
      DCA_CMD_RD  = 3'h5,
      DCA_CMD_BST = 3'h6,
      DCA_CMD_NOP = 3'h7
   } dca_cmd_t;

   typedef enum logic [1:0] {
      DCA_ST_IDLE  = 2'h0,
      DCA_ST_WRITE = 2'h1,
      DCA_ST_RWAIT = 2'h2,
      DCA_ST_READ  = 2'h3
   } dca_state_t;

endpackage : dca_pkg

`default_nettype wire

// ### src/dca_afifo.sv
`default_nettype none

module dca_afifo #(
   parameter int W     = 44,
   parameter int DEPTH = 16
) (
   input  wire logic         wclk,
   input  wire logic         wrst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   input  wire logic         rclk,
   input  wire logic         rrst_b,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wbin;
   logic [AW:0]  wgray;
   logic [AW:0]  rbin;
   logic [AW:0]  rgray;
   logic [AW:0]  wg_s1;
   logic [AW:0]  wg_s2;
   logic [AW:0]  rg_s1;
   logic [AW:0]  rg_s2;
   logic [AW:0]  next_wbin;
   logic [AW:0]  next_rbin;
   logic         push;
   logic         pop;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   // Full: write pointer a whole lap ahead of the synced read pointer
   assign in_ready  = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
   assign out_valid = (rgray != wg_s2);
   assign out_data  = mem[rbin[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign next_wbin = wbin + {{AW{1'b0}}, 1'b1};
   assign next_rbin = rbin + {{AW{1'b0}}, 1'b1};

   always_ff @(posedge wclk) begin
      if (push) begin
         mem[wbin[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge wclk or negedge wrst_b) begin
      if (!wrst_b) begin
         wbin  <= '0;
         wgray <= '0;
      end else if (push) begin
         wbin  <= next_wbin;
         wgray <= to_gray(next_wbin);
      end
   end

   always_ff @(posedge rclk or negedge rrst_b) begin
      if (!rrst_b) begin
         rbin  <= '0;
         rgray <= '0;
      end else if (pop) begin
         rbin  <= next_rbin;
         rgray <= to_gray(next_rbin);
      end
   end

   // Gray pointers cross through two flops each
   always_ff @(posedge wclk or negedge wrst_b) begin
      if (!wrst_b) begin
         rg_s1 <= '0;
         rg_s2 <= '0;
      end else begin
         rg_s1 <= rgray;
         rg_s2 <= rg_s1;
      end
   end

   always_ff @(posedge rclk or negedge rrst_b) begin
      if (!rrst_b) begin
         wg_s1 <= '0;
         wg_s2 <= '0;
      end else begin
         wg_s1 <= wgray;
         wg_s2 <= wg_s1;
      end
   end

endmodule : dca_afifo

`default_nettype wire

// ### src/dca_port.sv
`include "dca_cfg.svh"

`default_nettype none

// Notes on behaviour
// - Control and address pins are sampled on rising link clock edges only.
// - Clock enable low suspends command decoding; high keeps the device clocked.
// - Command decoder works only while chip select is sampled low.
// - With chip select high new commands are dropped; running bursts finish.
// - Command comes from row, column and write strobe levels at one edge.
// - Data moves on both link clock edges, two words per clock.
// - Read strobe edges are driven aligned with the read data transitions.
// - Activate takes all twelve address inputs as the row to open.
// - Read or write takes low address inputs as burst start column.
// - Address bit ten high on read or write closes the bank after the burst.
// - Precharge with address bit ten high closes all four banks.
// - Bank select inputs name the bank a command applies to.
// - Write data with mask high is blocked, mask low is stored.
// - Mode register write: all strobes and bank bit zero low, address stored.
// - Extended mode write needs bank bit zero high, all banks idle, enable high.
module dca_port (
   input  wire logic                      mclk,
   input  wire logic                      rst_b,
   input  wire logic                      link_clk,
   input  wire logic                      cke,
   input  wire logic                      cs_b,
   input  wire logic                      ras_b,
   input  wire logic                      cas_b,
   input  wire logic                      we_b,
   input  wire logic [`DCA_ADDR_W-1:0]    addr,
   input  wire logic [1:0]                ba,
   input  wire logic                      dm,
   input  wire logic [`DCA_DQ_W-1:0]      dq_i,
   output logic [`DCA_DQ_W-1:0]           dq_o,
   output logic                           dq_oe,
   input  wire logic                      dqs_i,
   output logic                           dqs_o,
   output logic                           dqs_oe,
   output logic                           cmd_valid,
   output dca_pkg::dca_cmd_t              cmd_code,
   output logic [1:0]                     cmd_bank,
   output logic [`DCA_ADDR_W-1:0]         cmd_addr,
   output logic                           power_down,
   output logic [2:0]                     mode_cl,
   output logic [2:0]                     mode_bl,
   output logic                           dll_en,
   output logic                           wr_overflow,
   output logic                           wr_valid,
   input  wire logic                      wr_ready,
   output logic [`DCA_FIFO_W-1:0]         wr_data
);
   import dca_pkg::*;
   // Reset release per domain
   logic [1:0]                   mrst_sync;
   logic [1:0]                   lrst_sync;
   logic                         m_rst_b;
   logic                         l_rst_b;
   // Link-domain state
   dca_cmd_t                     cmd;
   logic                         cmd_en;
   logic                         all_idle;
   logic [3:0]                   bank_open;
   logic [`DCA_ADDR_W-1:0]       mode_reg;
   logic [`DCA_EMR_W-1:0]        emode_reg;
   dca_state_t                   state;
   logic [`DCA_COL_W-1:0]        b_col;
   logic [1:0]                   b_bank;
   logic                         b_ap;
   logic [2:0]                   b_left;
   logic [3:0]                   b_beat;
   logic [2:0]                   b_lat;
   logic                         burst_done;
   logic                         wr_have;
   logic                         wr_commit;
   logic [`DCA_DQ_W-1:0]         wb0;
   logic                         wm0;
   logic [`DCA_DQ_W-1:0]         wb1;
   logic                         wm1;
   logic [`DCA_DQ_W-1:0]         mem [`DCA_MEM_WORDS];
   logic [`DCA_DQ_W-1:0]         rd_lo;
   logic [`DCA_DQ_W-1:0]         rd_hi;
   logic [`DCA_DQ_W-1:0]         rd_neg;
   logic                         drive;
   logic                         fifo_in_ready;
   logic                         ovf_l;
   logic                         cke_l;
   // Command report crossing
   logic                         rep_tog;
   logic [`DCA_ADDR_W+4:0]       rep_hold;
   logic [2:0]                   rep_sync;
   logic [1:0]                   pd_sync;
   logic [1:0]                   ovf_sync;
   logic [6:0]                   mode_s1;
   logic [6:0]                   mode_s2;
   // Burst length in clock pairs; unknown codes fall back to one pair
   function automatic logic [2:0] bl_pairs(input logic [2:0] code);
      unique case (code)
         `DCA_BL4: return 3'h2;
         `DCA_BL8: return 3'h4;
         default:  return 3'h1;
      endcase
   endfunction : bl_pairs
   // Sequential wrap within the burst length
   function automatic logic [`DCA_MEM_IDX_W-1:0] mem_idx(input logic [1:0] bank,
                                                         input logic [3:0] col,
                                                         input logic [3:0] beat,
                                                         input logic [2:0] code);
      logic [3:0] m;
      m = {bl_pairs(code), 1'b0} - 4'h1;
      return {bank, (col & ~m) | ((col + beat) & m)};
   endfunction : mem_idx
   // ---------------- reset release ----------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mrst_sync <= 2'h0;
      end else begin
         mrst_sync <= {mrst_sync[0], 1'b1};
      end
   end
   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         lrst_sync <= 2'h0;
      end else begin
         lrst_sync <= {lrst_sync[0], 1'b1};
      end
   end
   assign m_rst_b = mrst_sync[1];
   assign l_rst_b = lrst_sync[1];
   // ---------------- command decode (link clock) ----------------
   // Pins are launched by the controller on this same clock, so no synchroniser
   assign cmd      = dca_cmd_t'({ras_b, cas_b, we_b});
   assign cmd_en   = cke & ~cs_b;
   assign all_idle = ~|bank_open;
   assign burst_done = ((state == DCA_ST_WRITE) && !wr_have && b_left == 3'h0) ||
                       ((state == DCA_ST_READ) && b_left == 3'h0);
   always_ff @(posedge link_clk or negedge l_rst_b) begin
      if (!l_rst_b) begin
         bank_open <= 4'h0;
      end else begin
         if (burst_done && b_ap) begin
            bank_open[b_bank] <= 1'b0;
         end
         if (cmd_en) begin
            unique case (cmd)
               DCA_CMD_ACT: bank_open[ba] <= 1'b1;
               DCA_CMD_PRE: begin
                  if (addr[`DCA_AP_BIT]) begin
                     bank_open <= 4'h0;
                  end else begin
                     bank_open[ba] <= 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Mode writes only land while every bank is idle
   always_ff @(posedge link_clk or negedge l_rst_b) begin
      if (!l_rst_b) begin
         mode_reg  <= `DCA_MR_RST;
         emode_reg <= `DCA_EMR_RST;
      end else if (cmd_en && cmd == DCA_CMD_MRS && all_idle) begin
         if (!ba[0]) begin
            mode_reg <= addr;
         end else begin
            emode_reg <= {ba[1], addr};
         end
      end
   end
   // ---------------- burst engine ----------------
   assign wr_commit = (state == DCA_ST_WRITE) && wr_have;
   always_ff @(posedge link_clk or negedge l_rst_b) begin
      if (!l_rst_b) begin
         state   <= DCA_ST_IDLE;
         b_col   <= '0;
         b_bank  <= 2'h0;
         b_ap    <= 1'b0;
         b_left  <= 3'h0;
         b_beat  <= 4'h0;
         b_lat   <= 3'h0;
         wr_have <= 1'b0;
         drive   <= 1'b0;
      end else if (cmd_en && (cmd == DCA_CMD_RD || cmd == DCA_CMD_WR)) begin
         // A new column command cuts any burst still running
         b_col   <= addr[`DCA_COL_W-1:0];
         b_bank  <= ba;
         b_ap    <= addr[`DCA_AP_BIT];
         b_left  <= bl_pairs(mode_reg[`DCA_BL_MSB:`DCA_BL_LSB]);
         b_beat  <= 4'h0;
         wr_have <= 1'b0;
         drive   <= 1'b0;
         // Half-cycle latency is rounded up to the next whole clock
         b_lat   <= (mode_reg[`DCA_CL_MSB:`DCA_CL_LSB] == `DCA_CL2) ? 3'h2 : 3'h3;
         state   <= (cmd == DCA_CMD_WR) ? DCA_ST_WRITE : DCA_ST_RWAIT;
      end else begin
         unique case (state)
            DCA_ST_IDLE: ;
            DCA_ST_WRITE: begin
               if (wr_have) begin
                  b_beat <= b_beat + 4'h2;
               end
               if (b_left != 3'h0) begin
                  b_left  <= b_left - 3'h1;
                  wr_have <= 1'b1;
               end else begin
                  wr_have <= 1'b0;
                  if (!wr_have) begin
                     state <= DCA_ST_IDLE;
                  end
               end
            end
            DCA_ST_RWAIT: begin
               if (b_lat == 3'h1) begin
                  drive  <= 1'b1;
                  b_beat <= 4'h2;   // Second pair launches from beat two
                  b_left <= b_left - 3'h1;
                  state  <= DCA_ST_READ;
               end else begin
                  b_lat <= b_lat - 3'h1;
               end
            end
            DCA_ST_READ: begin
               b_beat <= b_beat + 4'h2;
               if (b_left != 3'h0) begin
                  b_left <= b_left - 3'h1;
               end else begin
                  drive <= 1'b0;
                  state <= DCA_ST_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------- write capture ----------------
   // First word on the rising edge, second on the falling edge
   always_ff @(posedge link_clk) begin
      if (state == DCA_ST_WRITE && b_left != 3'h0) begin
         wb0 <= dq_i;
         wm0 <= dm;
      end
   end

   always_ff @(negedge link_clk) begin
      if (wr_have) begin
         wb1 <= dq_i;
         wm1 <= dm;
      end
   end

   // Masked words leave the array untouched, written one clock after the first word is captured
   always_ff @(posedge link_clk) begin
      if (wr_commit && !wm0) begin
         mem[mem_idx(b_bank, b_col[3:0], b_beat, mode_reg[2:0])] <= wb0;
      end
      if (wr_commit && !wm1) begin
         mem[mem_idx(b_bank, b_col[3:0], b_beat + 4'h1, mode_reg[2:0])] <= wb1;
      end
   end

   // Sticky loss flag: the array still takes the word, only the report is dropped
   always_ff @(posedge link_clk or negedge l_rst_b) begin
      if (!l_rst_b) begin
         ovf_l <= 1'b0;
      end else if (wr_commit && !fifo_in_ready) begin
         ovf_l <= 1'b1;
      end
   end

   // ---------------- read launch ----------------
   always_ff @(posedge link_clk) begin
      if ((state == DCA_ST_RWAIT && b_lat == 3'h1) ||
          (state == DCA_ST_READ && b_left != 3'h0)) begin
         rd_lo <= mem[mem_idx(b_bank, b_col[3:0], b_beat, mode_reg[2:0])];
         rd_hi <= mem[mem_idx(b_bank, b_col[3:0], b_beat + 4'h1, mode_reg[2:0])];
      end
   end

   always_ff @(negedge link_clk) begin
      rd_neg <= rd_hi;
   end

   // Pin drivers follow the clock phase: a true DDR output cannot come from one flop
   assign dq_o   = link_clk ? rd_lo : rd_neg;
   assign dqs_o  = link_clk & drive;
   assign dq_oe  = drive;
   assign dqs_oe = drive;

   // ---------------- command report to the system clock ----------------
   always_ff @(posedge link_clk or negedge l_rst_b) begin
      if (!l_rst_b) begin
         rep_tog  <= 1'b0;
         rep_hold <= '0;
         cke_l    <= 1'b1;   // No false power-down report after reset
      end else begin
         cke_l <= cke;
         if (cmd_en && cmd != DCA_CMD_NOP) begin
            rep_hold <= {cmd, ba, addr};
            rep_tog  <= ~rep_tog;
         end
      end
   end
   // Hold is stable one link period, far longer than this three-flop path
   always_ff @(posedge mclk or negedge m_rst_b) begin
      if (!m_rst_b) begin
         rep_sync  <= 3'h0;
         cmd_valid <= 1'b0;
         cmd_code  <= DCA_CMD_NOP;
         cmd_bank  <= 2'h0;
         cmd_addr  <= '0;
      end else begin
         rep_sync  <= {rep_sync[1:0], rep_tog};
         cmd_valid <= rep_sync[2] ^ rep_sync[1];
         if (rep_sync[2] ^ rep_sync[1]) begin
            cmd_code <= dca_cmd_t'(rep_hold[`DCA_ADDR_W+4:`DCA_ADDR_W+2]);
            cmd_bank <= rep_hold[`DCA_ADDR_W+1:`DCA_ADDR_W];
            cmd_addr <= rep_hold[`DCA_ADDR_W-1:0];
         end
      end
   end

   // Mode fields only change with banks idle, so plain level syncs suffice
   always_ff @(posedge mclk or negedge m_rst_b) begin
      if (!m_rst_b) begin
         pd_sync  <= 2'h0;
         ovf_sync <= 2'h0;
         mode_s1  <= 7'h40;
         mode_s2  <= 7'h40;
      end else begin
         pd_sync  <= {pd_sync[0], ~cke_l};
         ovf_sync <= {ovf_sync[0], ovf_l};
         mode_s1  <= {~emode_reg[`DCA_DLL_BIT], mode_reg[`DCA_CL_MSB:`DCA_CL_LSB],
                      mode_reg[`DCA_BL_MSB:`DCA_BL_LSB]};
         mode_s2  <= mode_s1;
      end
   end

   assign power_down  = pd_sync[1];
   assign wr_overflow = ovf_sync[1];
   assign dll_en      = mode_s2[6];   // Inverted ahead of the sync flops
   assign mode_cl     = mode_s2[5:3];
   assign mode_bl     = mode_s2[2:0];

   // ---------------- write log towards the system clock ----------------
   dca_afifo #(
      .W     (`DCA_FIFO_W),
      .DEPTH (`DCA_FIFO_DEPTH)
   ) u_wlog (
      .wclk      (link_clk),
      .wrst_b    (l_rst_b),
      .in_valid  (wr_commit),
      .in_ready  (fifo_in_ready),
      .in_data   ({b_bank, b_col, wm1, wb1, wm0, wb0}),
      .rclk      (mclk),
      .rrst_b    (m_rst_b),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_data)
   );

endmodule : dca_port

`default_nettype wire

// ### verif/dca_port_sva.sv
`include "dca_cfg.svh"
`default_nettype none
module dca_port_sva import dca_pkg::*; (
   input wire logic                   mclk,
   input wire logic                   rst_b,
   input wire logic                   link_clk,
   input wire logic                   cke,
   input wire logic                   cs_b,
   input wire logic                   ras_b,
   input wire logic                   cas_b,
   input wire logic                   we_b,
   input wire logic                   dq_oe,
   input wire logic                   dqs_o,
   input wire logic                   dqs_oe,
   input wire logic                   cmd_valid,
   input wire dca_pkg::dca_cmd_t      cmd_code,
   input wire logic [1:0]             cmd_bank,
   input wire logic [`DCA_ADDR_W-1:0] cmd_addr,
   input wire logic                   power_down,
   input wire logic [2:0]             mode_cl,
   input wire logic [2:0]             mode_bl
);
   cmd_real_a: assert property (@(posedge mclk) disable iff (!rst_b)
      cmd_valid |-> cmd_code != DCA_CMD_NOP) else $error("nop reported");
   cmd_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
      cmd_valid |=> !cmd_valid) else $error("report longer than one cycle");
   cmd_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !cmd_valid |-> $stable(cmd_code) && $stable(cmd_bank) && $stable(cmd_addr))
      else $error("report changed without pulse");
   // Link edges never meet mclk edges in the bench, so sampling is clean
   oe_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
      dq_oe == dqs_oe) else $error("data and strobe drive differ");
   dqs_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
      dqs_o == (link_clk && dqs_oe)) else $error("strobe not edge aligned");
   pd_enter_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(power_down) |-> !cke) else $error("power down with enable high");
   pd_leave_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(power_down) |-> cke) else $error("power down left with enable low");
   rd_lat_a: assert property (@(posedge link_clk) disable iff (!rst_b)
      cke && !cs_b && {ras_b, cas_b, we_b} == DCA_CMD_RD && mode_cl == `DCA_CL2
      |-> ##2 !dq_oe ##1 dq_oe) else $error("read latency wrong");
   burst_len_a: assert property (@(posedge link_clk) disable iff (!rst_b)
      $rose(dq_oe) && mode_bl == `DCA_BL4 |-> ##1 dq_oe ##1 !dq_oe)
      else $error("read burst length wrong");
   desel_ignore_a: assert property (@(posedge link_clk) disable iff (!rst_b)
      (cs_b || !cke) [*5] |-> !$rose(dq_oe)) else $error("deselected read ran");
endmodule : dca_port_sva
bind dca_port dca_port_sva chk_i (.*);
`default_nettype wire

// ### verif/dca_ctl_model.sv
`include "dca_cfg.svh"
`default_nettype none
module dca_ctl_model import dca_pkg::*; (
   output logic                   link_clk,
   output logic                   cke,
   output logic                   cs_b,
   output logic                   ras_b,
   output logic                   cas_b,
   output logic                   we_b,
   output logic [`DCA_ADDR_W-1:0] addr,
   output logic [1:0]             ba,
   output logic                   dm,
   output logic [`DCA_DQ_W-1:0]   dq_i,
   output logic                   dqs_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Odd offset keeps link edges clear of mclk edges
   initial begin
      {cs_b, ras_b, cas_b, we_b, cke} = 5'h1F;
      addr = 12'h000;
      ba = 2'h0;
      dm = 1'b0;
      dq_i = 16'h0000;
      dqs_i = 1'b0;
      link_clk = 1'b0;
      #7.3;
      forever #32 link_clk = ~link_clk;
   end
   task idle(input int n);
      repeat (n) @(negedge link_clk);
   endtask : idle
   task set_cke(input logic v);
      @(negedge link_clk);
      cke <= v;
   endtask : set_cke
   task cmd(input dca_cmd_t c, input logic [1:0] b, input logic [11:0] a, input logic sel);
      @(negedge link_clk);
      cs_b <= ~sel;
      {ras_b, cas_b, we_b} <= c;
      ba <= b;
      addr <= a;
      @(negedge link_clk);
      cs_b <= 1'b1;
      {ras_b, cas_b, we_b} <= DCA_CMD_NOP;
      // Deselected lines flip so stale values cannot pass
      ba <= ~b;
      addr <= ~a;
   endtask : cmd
   task wr(input logic [1:0] b, input logic [11:0] a, input int n, input logic [15:0] base,
           input logic [7:0] m);
      int i;
      cmd(DCA_CMD_WR, b, a, 1'b1);
      for (i = 0; i < 2 * n; i++) begin
         if (i % 2 == 1) @(posedge link_clk);
         else if (i > 0) @(negedge link_clk);
         dq_i <= base + 16'(i);
         dm <= m[i];
         dqs_i <= #16 (i % 2 == 0);
      end
      @(negedge link_clk);
      dq_i <= ~dq_i;
      dm <= ~dm;
      dqs_i <= 1'b1;
   endtask : wr
endmodule : dca_ctl_model
`default_nettype wire

// ### verif/test_ddr_sdram_command_address_port.sv
`include "dca_cfg.svh"
`default_nettype none
module test_ddr_sdram_command_address_port import dca_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic                   mclk = 1'b0;
   logic                   rst_b, wr_ready, link_clk, cke, cs_b, ras_b, cas_b, we_b, dm;
   logic                   dqs_i, dq_oe, dqs_o, dqs_oe, cmd_valid, power_down, dll_en;
   logic                   wr_overflow, wr_valid;
   logic [`DCA_ADDR_W-1:0] addr, cmd_addr;
   logic [1:0]             ba, cmd_bank;
   logic [`DCA_DQ_W-1:0]   dq_i, dq_o;
   logic [2:0]             mode_cl, mode_bl;
   dca_cmd_t               cmd_code;
   logic [`DCA_FIFO_W-1:0] wr_data;
   int                     failures = 0;
   int                     cmp_count = 0;
   always #2.5 mclk = ~mclk;
   dca_port uut (.*);
   dca_ctl_model ctl (.*);
   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task see(input dca_cmd_t c, input logic [1:0] b, input logic [11:0] a);
      int k;
      for (k = 0; k < 60 && cmd_valid !== 1'b1; k++) @(negedge mclk);
      chk(cmd_valid === 1'b1 && cmd_code === c && cmd_bank === b && cmd_addr === a,
          "command report");
   endtask : see
   task issue(input dca_cmd_t c, input logic [1:0] b, input logic [11:0] a);
      fork
         ctl.cmd(c, b, a, 1'b1);
         see(c, b, a);
      join
   endtask : issue
   task settle;
      ctl.idle(2);
      repeat (8) @(negedge mclk);
   endtask : settle
   task quiet(input logic sel);
      logic hit;
      hit = 1'b0;
      fork
         ctl.cmd(DCA_CMD_ACT, 2'h0, 12'h123, sel);
         repeat (40) @(negedge mclk) if (cmd_valid === 1'b1) hit = 1'b1;
      join
      chk(!hit, "ignored command reported");
   endtask : quiet
   task pop(output logic [`DCA_FIFO_W-1:0] d);
      int k;
      @(negedge mclk);
      for (k = 0; k < 100 && wr_valid !== 1'b1; k++) @(negedge mclk);
      chk(wr_valid === 1'b1, "no logged pair");
      d = wr_data;
      wr_ready = 1'b1;
      @(negedge mclk);
      wr_ready = 1'b0;
   endtask : pop
   task t_mode;
      issue(DCA_CMD_MRS, 2'h0, 12'h022);
      settle;
      chk(mode_bl === `DCA_BL4 && mode_cl === `DCA_CL2, "mode fields");
      issue(DCA_CMD_MRS, 2'h1, 12'h001);
      settle;
      chk(dll_en === 1'b0, "dll still on");
      issue(DCA_CMD_MRS, 2'h1, 12'h000);
      settle;
      chk(dll_en === 1'b1, "dll still off");
   endtask : t_mode
   task t_desel;
      quiet(1'b0);
      ctl.set_cke(1'b0);
      quiet(1'b1);
      chk(power_down === 1'b1, "no power down");
      ctl.set_cke(1'b1);
      settle;
      chk(power_down === 1'b0, "stuck in power down");
   endtask : t_desel
   task t_rw;
      logic [`DCA_FIFO_W-1:0] d;
      logic [15:0]            w0;
      int                     k;
      wr_ready = 1'b0;
      issue(DCA_CMD_ACT, 2'h1, 12'h5A5);
      ctl.wr(2'h1, 12'h004, 2, 16'hA000, 8'h00);
      ctl.wr(2'h1, 12'h004, 2, 16'hB000, 8'h02);
      for (k = 0; k < 4; k++) begin
         pop(d);
         w0 = (k < 2 ? 16'hA000 : 16'hB000) + 16'(2 * (k % 2));
         chk(d[43:42] === 2'h1 && d[15:0] === w0 && d[32:17] === w0 + 16'h0001, "pair");
         chk(d[33] === (k == 2) && d[16] === 1'b0, "pair mask");
      end
      ctl.cmd(DCA_CMD_RD, 2'h1, 12'h404, 1'b1);
      @(posedge link_clk);
      for (k = 0; k < 4; k++) begin
         if (k % 2 == 0) @(posedge link_clk);
         else @(negedge link_clk);
         #8;
         w0 = (k == 1) ? 16'hA001 : 16'hB000 + 16'(k);
         chk(dq_oe === 1'b1 && dq_o === w0 && dqs_o === (k % 2 == 0), "read word");
      end
      @(posedge link_clk);
      #8;
      chk(dq_oe === 1'b0 && dqs_oe === 1'b0, "drive after burst");
      issue(DCA_CMD_MRS, 2'h0, 12'h023);
      settle;
      chk(mode_bl === `DCA_BL8, "bank left open");
   endtask : t_rw
   task t_bank;
      issue(DCA_CMD_ACT, 2'h0, 12'h011);
      issue(DCA_CMD_ACT, 2'h2, 12'h022);
      issue(DCA_CMD_PRE, 2'h0, 12'h000);
      issue(DCA_CMD_MRS, 2'h0, 12'h022);
      settle;
      chk(mode_bl === `DCA_BL8, "mode written with bank open");
      issue(DCA_CMD_PRE, 2'h3, 12'h400);
      issue(DCA_CMD_MRS, 2'h0, 12'h022);
      settle;
      chk(mode_bl === `DCA_BL4, "bank missed by precharge all");
   endtask : t_bank
   // Far side cannot be stalled, so overrun is only flagged
   task t_fifo;
      int n;
      issue(DCA_CMD_ACT, 2'h3, 12'h0F0);
      for (n = 0; n < 9; n++) ctl.wr(2'h3, 12'(2 * n), 2, 16'hC000, 8'h00);
      repeat (20) @(negedge mclk);
      chk(wr_overflow === 1'b1 && wr_valid === 1'b1, "full buffer not flagged");
      for (n = 0; n < 40; n++) begin
         @(negedge mclk);
         if (wr_valid !== 1'b1) break;
         wr_ready = 1'b1;
         @(negedge mclk);
         wr_ready = 1'b0;
      end
      chk(n == 16 && wr_overflow === 1'b1, "buffer depth");
   endtask : t_fifo
   initial begin
      rst_b = 1'b0;
      wr_ready = 1'b0;
      repeat (8) @(negedge link_clk);
      rst_b = 1'b1;
      ctl.idle(5);
      t_mode;
      t_desel;
      t_rw;
      t_bank;
      t_fifo;
      report_and_stop;
   end
   initial begin
      #100000;
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop;
   end
endmodule : test_ddr_sdram_command_address_port
`default_nettype wire
